// [pfpc_top.sv]
// Persistence filters, wait extension, gain and pulse control with APB registers
//
// Contract
// - Proximity code bits 7:4, resets zero; code zero gives an event every cycle.
// - Proximity code one gives an event on any single out-of-window result.
// - Proximity codes two to fifteen need that many consecutive out-of-window results.
// - Light code bits 3:0, resets zero; zero every cycle, one any single result.
// - Light codes two, three need that many; four up need five times code minus three.
// - Proximity out-of-window results are counted; event when count equals the code.
// - An inside proximity result clears the proximity counter.
// - Light out-of-range results are counted; event when count equals the light setting.
// - An inside light result clears the light counter.
// - Proximity wait-extend bit 3 multiplies the proximity wait period by twelve.
// - Light wait-extend bit 2 multiplies the light wait period by twelve.
// - Stage-one gain bits 7:6 reset two; codes select 1x to 8x, times stage two.
// - Pulse field bits 5:0 resets fifteen; pulses per cycle are field plus one.
// - With auto pulse control, pulses stop at the limit or near saturation.
// - Auto pulse off by bit 6 of config six sends exactly the programmed pulses.
// - Light out of range above high threshold; sets flag, drives pin if enabled.
// - Proximity out of range below low or above high; breach at persistence count.
//
// Chosen here: register access over APB.
`timescale 1ns/100ps
module pfpc_top (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [pfpc_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Measurement engine
   input wire logic prox_cycle_start,
   input wire logic light_cycle_start,
   input wire pfpc_pkg::pfpc_prox_s prox_in,
   input wire pfpc_pkg::pfpc_light_s light_in,
   input wire logic near_saturation,
   input wire logic [1:0] prox_gain_stage_two,
   input wire logic [7:0] prox_wait_period,
   input wire logic [7:0] light_wait_period,
   // Events and interrupt pin
   output logic prox_event,
   output logic light_event,
   output logic light_int_flag,
   output logic prox_int_flag,
   output logic int_pin,
   // Emitter and configuration outputs
   output logic ir_pulse,
   output logic pulse_active,
   output logic [6:0] pulses_sent,
   output logic [11:0] prox_wait_scaled,
   output logic [11:0] light_wait_scaled,
   output logic [9:0] prox_gain_total_x10
);
   logic [7:0] persist_ctrl_r;
   logic [7:0] wait_cfg_r;
   logic [7:0] gain_pulse_r;
   logic [7:0] cfg_six_r;
   logic [7:0] int_ctrl_r;
   logic pready_r;
   logic pslverr_r;
   logic [31:0] prdata_r;
   logic [7:0] idx;
   logic mapped;
   logic wr_en;
   logic rd_en;
   logic lane0;
   logic [7:0] rd_val;
   logic prox_out;
   logic light_out;
   logic prox_ev;
   logic light_ev;
   logic [5:0] prox_cnt;
   logic [5:0] light_cnt;
   logic light_flag_r;
   logic prox_flag_r;
   logic int_pin_r;
   logic [6:0] pulse_lim_r;
   logic auto_lat_r;
   logic [6:0] pulse_cnt_r;
   logic pulse_active_r;
   logic ir_pulse_r;
   logic [11:0] prox_wait_r;
   logic [11:0] light_wait_r;
   logic [9:0] gain_total_r;
   logic [3:0] stage_one_x;
   logic [6:0] stage_two_x10;

   // Address decode
   assign idx = paddr[9:2];
   assign lane0 = pstrb[0];
   always_comb
   begin
      case (idx)
         pfpc_pkg::IDX_PERSIST: mapped = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
         pfpc_pkg::IDX_WAIT_CFG: mapped = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
         pfpc_pkg::IDX_GAIN_PULSE: mapped = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
         pfpc_pkg::IDX_CFG_SIX: mapped = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
         pfpc_pkg::IDX_INT_CTRL: mapped = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
         pfpc_pkg::IDX_INT_STATUS: mapped = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
         default: mapped = 1'b0;
      endcase
   end
   assign wr_en = psel && penable && pready_r && pwrite && mapped && lane0;
   assign rd_en = psel && penable && !pready_r && !pwrite;

   // Read mux
   always_comb
   begin
      case (idx)
         pfpc_pkg::IDX_PERSIST: rd_val = persist_ctrl_r;
         pfpc_pkg::IDX_WAIT_CFG: rd_val = wait_cfg_r;
         pfpc_pkg::IDX_GAIN_PULSE: rd_val = gain_pulse_r;
         pfpc_pkg::IDX_CFG_SIX: rd_val = cfg_six_r;
         pfpc_pkg::IDX_INT_CTRL: rd_val = int_ctrl_r;
         pfpc_pkg::IDX_INT_STATUS: rd_val = {6'h00, prox_flag_r, light_flag_r};
         default: rd_val = 8'h00;
      endcase
   end

   // One wait state, then ready with data
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h00000000;
      end
      else
      begin
         pready_r <= psel && penable && !pready_r;
         pslverr_r <= psel && penable && !pready_r && !mapped;
         if (rd_en)
            prdata_r <= mapped ? {24'h000000, rd_val} : 32'h00000000;
      end
   end

   // Persistence control register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         persist_ctrl_r <= pfpc_pkg::RST_PERSIST;
      else if (wr_en && idx == pfpc_pkg::IDX_PERSIST)
         persist_ctrl_r <= pwdata[7:0];
   end

   // Wait configuration; reserved bits stored as written
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         wait_cfg_r <= pfpc_pkg::RST_WAIT_CFG;
      else if (wr_en && idx == pfpc_pkg::IDX_WAIT_CFG)
         wait_cfg_r <= pwdata[7:0];
   end

   // Gain and pulse register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         gain_pulse_r <= pfpc_pkg::RST_GAIN_PULSE;
      else if (wr_en && idx == pfpc_pkg::IDX_GAIN_PULSE)
         gain_pulse_r <= pwdata[7:0];
   end

   // Config six and interrupt enables
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cfg_six_r <= pfpc_pkg::RST_CFG_SIX;
         int_ctrl_r <= pfpc_pkg::RST_INT_CTRL;
      end
      else
      begin
         if (wr_en && idx == pfpc_pkg::IDX_CFG_SIX)
            cfg_six_r <= pwdata[7:0];
         if (wr_en && idx == pfpc_pkg::IDX_INT_CTRL)
            int_ctrl_r <= {6'h00, pwdata[1:0]};
      end
   end

   // Out-of-range tests
   assign prox_out = (prox_in.result < prox_in.low_thresh) || (prox_in.result > prox_in.high_thresh);
   assign light_out = light_in.result > light_in.high_thresh;

   // Proximity filter, code used directly as count
   pfpc_persist_filter #(.CNT_W(pfpc_pkg::CNT_W)) u_prox_filter (
      .pclk(pclk),
      .presetn(presetn),
      .cycle_start(prox_cycle_start),
      .need({2'h0, persist_ctrl_r[pfpc_pkg::PROX_PERSISTENCE_FILTER_CTRL_HI:pfpc_pkg::PROX_PERSISTENCE_FILTER_CTRL_LO]}),
      .result_valid(prox_in.valid),
      .out_of_range(prox_out),
      .event_r(prox_ev),
      .count_r(prox_cnt)
   );

   // Light filter, code mapped to a count
   pfpc_persist_filter #(.CNT_W(pfpc_pkg::CNT_W)) u_light_filter (
      .pclk(pclk),
      .presetn(presetn),
      .cycle_start(light_cycle_start),
      .need(pfpc_pkg::light_need(persist_ctrl_r[pfpc_pkg::LIGHT_PERSISTENCE_FILTER_CTRL_HI:pfpc_pkg::LIGHT_PERSISTENCE_FILTER_CTRL_LO])),
      .result_valid(light_in.valid),
      .out_of_range(light_out),
      .event_r(light_ev),
      .count_r(light_cnt)
   );

   // Sticky flags, set wins over a write-one clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         light_flag_r <= 1'b0;
         prox_flag_r <= 1'b0;
      end
      else
      begin
         if (light_ev)
            light_flag_r <= 1'b1;
         else if (wr_en && idx == pfpc_pkg::IDX_INT_STATUS && pwdata[pfpc_pkg::LIGHT_FLAG_BIT])
            light_flag_r <= 1'b0;
         if (prox_ev)
            prox_flag_r <= 1'b1;
         else if (wr_en && idx == pfpc_pkg::IDX_INT_STATUS && pwdata[pfpc_pkg::PROX_FLAG_BIT])
            prox_flag_r <= 1'b0;
      end
   end

   // Interrupt pin
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         int_pin_r <= 1'b0;
      else
         int_pin_r <= (light_flag_r && int_ctrl_r[pfpc_pkg::LIGHT_INT_EN_BIT])
            || (prox_flag_r && int_ctrl_r[pfpc_pkg::PROX_INT_EN_BIT]);
   end

   // Pulse limit and mode taken at cycle start
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pulse_lim_r <= 7'h10;
         auto_lat_r <= 1'b1;
      end
      else if (prox_cycle_start)
      begin
         pulse_lim_r <= 7'({1'b0, gain_pulse_r[pfpc_pkg::PULSE_HI:pfpc_pkg::PULSE_LO]} + 7'h01);
         auto_lat_r <= !cfg_six_r[pfpc_pkg::AUTO_PULSE_OFF_BIT];
      end
   end

   // Pulse engine
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pulse_cnt_r <= 7'h00;
         pulse_active_r <= 1'b0;
         ir_pulse_r <= 1'b0;
      end
      else if (prox_cycle_start)
      begin
         pulse_cnt_r <= 7'h00;
         pulse_active_r <= 1'b1;
         ir_pulse_r <= 1'b0;
      end
      else if (pulse_active_r)
      begin
         if (pulse_cnt_r >= pulse_lim_r || (auto_lat_r && near_saturation))
         begin
            pulse_active_r <= 1'b0;
            ir_pulse_r <= 1'b0;
         end
         else
         begin
            pulse_cnt_r <= 7'(pulse_cnt_r + 7'h01);
            ir_pulse_r <= 1'b1;
         end
      end
      else
         ir_pulse_r <= 1'b0;
   end

   // Gain factors
   assign stage_one_x = 4'(4'h1 << gain_pulse_r[pfpc_pkg::GAIN1_HI:pfpc_pkg::GAIN1_LO]);
   always_comb
   begin
      case (prox_gain_stage_two)
         2'h0: stage_two_x10 = 7'h19;
         2'h1: stage_two_x10 = 7'h32;
         2'h3: stage_two_x10 = 7'h64;
         default: stage_two_x10 = 7'h00;
      endcase
   end

   // Scaled wait periods and total gain
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prox_wait_r <= 12'h000;
         light_wait_r <= 12'h000;
         gain_total_r <= 10'h000;
      end
      else
      begin
         prox_wait_r <= pfpc_pkg::wait_scale(prox_wait_period, wait_cfg_r[pfpc_pkg::PROX_WAIT_EXT_BIT]);
         light_wait_r <= pfpc_pkg::wait_scale(light_wait_period,
            wait_cfg_r[pfpc_pkg::LIGHT_WAIT_EXT_BIT]);
         gain_total_r <= 10'(stage_one_x) * 10'(stage_two_x10);
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign prox_event = prox_ev;
   assign light_event = light_ev;
   assign light_int_flag = light_flag_r;
   assign prox_int_flag = prox_flag_r;
   assign int_pin = int_pin_r;
   assign ir_pulse = ir_pulse_r;
   assign pulse_active = pulse_active_r;
   assign pulses_sent = pulse_cnt_r;
   assign prox_wait_scaled = prox_wait_r;
   assign light_wait_scaled = light_wait_r;
   assign prox_gain_total_x10 = gain_total_r;

   a_pulse_limit_held: assert property (@(posedge pclk) disable iff (!presetn)
      pulse_cnt_r <= pulse_lim_r || $past(prox_cycle_start))
      else $error("pulse count above limit");

   a_manual_exact_pulses: assert property (@(posedge pclk) disable iff (!presetn)
      ($fell(pulse_active_r) && !auto_lat_r && !$past(prox_cycle_start)) |-> (pulse_cnt_r == pulse_lim_r))
      else $error("manual mode ended short");

   a_sat_stops_pulses: assert property (@(posedge pclk) disable iff (!presetn)
      (pulse_active_r && auto_lat_r && near_saturation && !prox_cycle_start) |=> (!pulse_active_r && !ir_pulse_r))
      else $error("pulses continued at saturation");

   a_light_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
      light_ev |=> light_flag_r)
      else $error("light flag not set");

   a_int_pin_follows: assert property (@(posedge pclk) disable iff (!presetn)
      (light_flag_r && int_ctrl_r[pfpc_pkg::LIGHT_INT_EN_BIT]) |=> int_pin_r)
      else $error("interrupt pin not driven");

   a_wait_extend_twelve: assert property (@(posedge pclk) disable iff (!presetn)
      $past(wait_cfg_r[pfpc_pkg::PROX_WAIT_EXT_BIT]) |-> (prox_wait_r == 12'($past(prox_wait_period)) * 12'h00C))
      else $error("proximity wait not extended");

   a_light_code_five: assert property (@(posedge pclk) disable iff (!presetn)
      (light_cycle_start && persist_ctrl_r[3:0] == 4'h4) |=> (u_light_filter.need_r == 6'h05))
      else $error("light code four not five results");

   a_write_next_cycle: assert property (@(posedge pclk) disable iff (!presetn)
      (!prox_cycle_start && !$past(prox_cycle_start)) |-> $stable(pulse_lim_r))
      else $error("pulse limit changed mid cycle");
endmodule

// [pfpc_pkg.sv]
// Package with offsets, reset values, carriers and helpers for the persistence filter block
package pfpc_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_PERSIST = 8'h8C;
   localparam logic [7:0] IDX_WAIT_CFG = 8'h8D;
   localparam logic [7:0] IDX_GAIN_PULSE = 8'h8E;
   localparam logic [7:0] IDX_CFG_SIX = 8'hAB;
   localparam logic [7:0] IDX_INT_CTRL = 8'hA1;
   localparam logic [7:0] IDX_INT_STATUS = 8'hA0;
   localparam int ADDR_W = 12;
   localparam int CNT_W = 6;
   // Reset values
   localparam logic [7:0] RST_PERSIST = 8'h00;
   localparam logic [7:0] RST_WAIT_CFG = 8'h50;
   localparam logic [7:0] RST_GAIN_PULSE = 8'h8F;
   localparam logic [7:0] RST_CFG_SIX = 8'h00;
   localparam logic [7:0] RST_INT_CTRL = 8'h00;
   // Field positions
   localparam int PROX_PERSISTENCE_FILTER_CTRL_HI = 7;
   localparam int PROX_PERSISTENCE_FILTER_CTRL_LO = 4;
   localparam int LIGHT_PERSISTENCE_FILTER_CTRL_HI = 3;
   localparam int LIGHT_PERSISTENCE_FILTER_CTRL_LO = 0;
   localparam int PROX_WAIT_EXT_BIT = 3;
   localparam int LIGHT_WAIT_EXT_BIT = 2;
   localparam int GAIN1_HI = 7;
   localparam int GAIN1_LO = 6;
   localparam int PULSE_HI = 5;
   localparam int PULSE_LO = 0;
   localparam int AUTO_PULSE_OFF_BIT = 6;
   localparam int LIGHT_INT_EN_BIT = 0;
   localparam int PROX_INT_EN_BIT = 1;
   localparam int LIGHT_FLAG_BIT = 0;
   localparam int PROX_FLAG_BIT = 1;
   // Wait extension factor
   localparam logic [3:0] WAIT_EXT_FACTOR = 4'hC;
   localparam int WAIT_W = 12;

   // Proximity result with its threshold window
   typedef struct packed
   {
      logic valid;
      logic [13:0] result;
      logic [13:0] low_thresh;
      logic [13:0] high_thresh;
   } pfpc_prox_s;

   // Light channel zero result with its high threshold
   typedef struct packed
   {
      logic valid;
      logic [15:0] result;
      logic [15:0] high_thresh;
   } pfpc_light_s;

   // Consecutive results needed for a light persistence code
   function automatic logic [5:0] light_need(input logic [3:0] code);
      logic [5:0] c;
      c = {2'h0, code};
      if (code <= 4'h3)
         light_need = c;
      else
         light_need = 6'(6'h5 * (c - 6'h3));
   endfunction

   // Wait period scaled by the extension bit
   function automatic logic [11:0] wait_scale(input logic [7:0] period, input logic ext);
      if (ext)
         wait_scale = 12'(period) * 12'(WAIT_EXT_FACTOR);
      else
         wait_scale = {4'h0, period};
   endfunction
endpackage

// [pfpc_persist_filter.sv]
// Consecutive out-of-range counter with persistence compare
`timescale 1ns/100ps
module pfpc_persist_filter #(
   parameter int CNT_W = 6
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Cycle and result
   input wire logic cycle_start,
   input wire logic [CNT_W-1:0] need,
   input wire logic result_valid,
   input wire logic out_of_range,
   // Event and count
   output logic event_r,
   output logic [CNT_W-1:0] count_r
);
   logic [CNT_W-1:0] need_r;
   logic [CNT_W-1:0] count_nxt;

   // Code taken at cycle start
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         need_r <= '0;
      else if (cycle_start)
         need_r <= need;
   end

   // Saturating count
   always_comb
   begin
      if (!out_of_range)
         count_nxt = '0;
      else if (count_r >= need_r)
         count_nxt = need_r;
      else
         count_nxt = CNT_W'(count_r + 1'b1);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         count_r <= '0;
      else if (result_valid)
         count_r <= count_nxt;
   end

   // Event on each result meeting the count, or every result for code zero
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         event_r <= 1'b0;
      else
         event_r <= result_valid && ((need_r == '0) || (out_of_range && count_nxt == need_r));
   end

   a_code_zero_every: assert property (@(posedge pclk) disable iff (!presetn)
      (result_valid && need_r == '0) |=> event_r)
      else $error("code zero result gave no event");

   a_inside_clears: assert property (@(posedge pclk) disable iff (!presetn)
      (result_valid && !out_of_range) |=> (count_r == '0))
      else $error("counter not cleared on inside result");

   a_count_saturates: assert property (@(posedge pclk) disable iff (!presetn)
      (result_valid && need_r != '0) |=> (count_r <= $past(need_r)))
      else $error("counter passed its code");

   a_event_needs_count: assert property (@(posedge pclk) disable iff (!presetn)
      (event_r && $past(need_r) != '0) |-> (count_r == $past(need_r) && $past(out_of_range)))
      else $error("event before count reached");
endmodule

// [pfpc_host_model.sv]
// Host model issuing APB register transfers
`timescale 1ns/100ps
module pfpc_host_model (
   // Clock
   input wire logic pclk,
   // APB master side
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [pfpc_pkg::ADDR_W-1:0] paddr,
   output logic [31:0] pwdata,
   output logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      pstrb = 4'hF;
   end

   // One transfer; held until pready is seen high, for at most 50 extra cycles
   task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                       output logic [7:0] rd, output logic err);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= 12'({idx, 2'h0});
      pwdata <= {24'h0, wd};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50)
      begin
         @(posedge pclk);
         n++;
      end
      rd = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~paddr;
      pwdata <= ~pwdata;
   endtask
endmodule

// [tb_top.sv]
// Self-checking bench for the persistence filter block
`timescale 1ns/100ps
module tb_top;
   typedef struct packed
   {
      logic is_light;
      logic [3:0] code;
      logic [6:0] n;
      logic [63:0] mask;
   } pfpc_row_s;
   localparam pfpc_row_s ROWS [9] = '{
      '{1'b0, 4'h0, 7'h03, 64'h0}, '{1'b0, 4'h1, 7'h04, 64'hA},
      '{1'b0, 4'h3, 7'h08, 64'hE6}, '{1'b0, 4'hF, 7'h11, 64'h1FFFE},
      '{1'b1, 4'h0, 7'h02, 64'h0}, '{1'b1, 4'h1, 7'h03, 64'h6},
      '{1'b1, 4'h3, 7'h06, 64'h3B}, '{1'b1, 4'h4, 7'h07, 64'h3E},
      '{1'b1, 4'hF, 7'h3E, 64'h3FFFFFFFFFFFFFFE}};
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [pfpc_pkg::ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0] pstrb;
   logic prox_cycle_start, light_cycle_start, near_saturation;
   pfpc_pkg::pfpc_prox_s prox_in;
   pfpc_pkg::pfpc_light_s light_in;
   logic [1:0] prox_gain_stage_two;
   logic [7:0] prox_wait_period, light_wait_period;
   logic prox_event, light_event, light_int_flag, prox_int_flag, int_pin, ir_pulse, pulse_active;
   logic [6:0] pulses_sent;
   logic [11:0] prox_wait_scaled, light_wait_scaled;
   logic [9:0] prox_gain_total_x10;
   logic [7:0] rdat;
   logic err, ev, ev_exp;
   int num_errors, checks_done, cycles, need, n;
   int cnt [2];

   pfpc_host_model u_host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr);
   pfpc_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
      .pslverr, .prox_cycle_start, .light_cycle_start, .prox_in, .light_in, .near_saturation,
      .prox_gain_stage_two, .prox_wait_period, .light_wait_period, .prox_event, .light_event,
      .light_int_flag, .prox_int_flag, .int_pin, .ir_pulse, .pulse_active, .pulses_sent,
      .prox_wait_scaled, .light_wait_scaled, .prox_gain_total_x10);

   initial
   begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp)
      begin
         $display("Error %s expected %h seen %h", name, exp, got);
         num_errors++;
      end
   endtask

   task automatic finish_test();
      if (num_errors == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      u_host.xfer(1'b1, idx, d, rdat, err);
   endtask

   task automatic rd(input logic [7:0] idx);
      u_host.xfer(1'b0, idx, 8'h00, rdat, err);
   endtask

   // Pulse a measurement cycle start
   task automatic start(input logic lt);
      @(posedge pclk);
      if (lt)
         light_cycle_start <= 1'b1;
      else
         prox_cycle_start <= 1'b1;
      @(posedge pclk);
      light_cycle_start <= 1'b0;
      prox_cycle_start <= 1'b0;
   endtask

   // One result; out proximity results alternate below and above the window, out light results go above
   task automatic send(input logic lt, input logic out, input int i, output logic e);
      @(posedge pclk);
      if (lt)
         light_in <= {1'b1, out ? 16'h07D0 : 16'h01F4, 16'h03E8};
      else
         prox_in <= {1'b1, out ? (i[0] ? 14'h012C : 14'h0032) : 14'h0096, 14'h0064, 14'h00C8};
      @(posedge pclk);
      light_in.valid <= 1'b0;
      prox_in.valid <= 1'b0;
      @(negedge pclk);
      e = lt ? light_event : prox_event;
   endtask

   task automatic run_pulses();
      start(1'b0);
      n = 0;
      repeat (80)
      begin
         @(negedge pclk);
         if (ir_pulse === 1'b1)
            n++;
      end
      @(posedge pclk);
   endtask

   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         num_errors++;
         finish_test();
      end
   end

   initial
   begin
      presetn = 1'b0;
      prox_cycle_start = 1'b0;
      light_cycle_start = 1'b0;
      near_saturation = 1'b0;
      prox_in = '0;
      light_in = '0;
      prox_gain_stage_two = 2'h0;
      prox_wait_period = 8'h15;
      light_wait_period = 8'hFF;
      cnt = '{0, 0};
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rd(pfpc_pkg::IDX_PERSIST);
      check("persist reset", 32'h00, rdat);
      rd(pfpc_pkg::IDX_WAIT_CFG);
      check("wait reset", 32'h50, rdat);
      rd(pfpc_pkg::IDX_GAIN_PULSE);
      check("gain reset", 32'h8F, rdat);
      rd(8'h00);
      check("unmapped err", 32'h1, err);
      check("unmapped data", 32'h0, rdat);
      foreach (ROWS[k])
      begin
         need = ROWS[k].is_light && ROWS[k].code > 3 ? 5 * (ROWS[k].code - 3) : ROWS[k].code;
         wr(pfpc_pkg::IDX_PERSIST, ROWS[k].is_light ? {4'h0, ROWS[k].code} : {ROWS[k].code, 4'h0});
         start(ROWS[k].is_light);
         for (int i = 0; i < ROWS[k].n; i++)
         begin
            if (!ROWS[k].mask[i])
               cnt[ROWS[k].is_light] = 0;
            else if (cnt[ROWS[k].is_light] < need)
               cnt[ROWS[k].is_light]++;
            send(ROWS[k].is_light, ROWS[k].mask[i], i, ev);
            ev_exp = need == 0 || (ROWS[k].mask[i] && cnt[ROWS[k].is_light] == need);
            check("event", ev_exp, ev);
         end
      end
      wr(pfpc_pkg::IDX_WAIT_CFG, 8'h58);
      repeat (3) @(posedge pclk);
      check("prox wait", 32'h0FC, prox_wait_scaled);
      check("light wait", 32'h0FF, light_wait_scaled);
      wr(pfpc_pkg::IDX_WAIT_CFG, 8'h54);
      repeat (3) @(posedge pclk);
      check("prox wait", 32'h015, prox_wait_scaled);
      check("light wait", 32'hBF4, light_wait_scaled);
      wr(pfpc_pkg::IDX_GAIN_PULSE, 8'hC3);
      repeat (3) @(posedge pclk);
      check("gain", 32'h0C8, prox_gain_total_x10);
      wr(pfpc_pkg::IDX_CFG_SIX, 8'h40);
      run_pulses();
      check("fixed pulses", 32'd4, n);
      check("pulses sent", 32'd4, pulses_sent);
      check("pulse active", 32'h0, pulse_active);
      wr(pfpc_pkg::IDX_CFG_SIX, 8'h00);
      run_pulses();
      check("auto pulses", 32'd4, n);
      near_saturation <= 1'b1;
      run_pulses();
      check("auto saturated", 32'd0, n);
      wr(pfpc_pkg::IDX_CFG_SIX, 8'h40);
      run_pulses();
      check("manual saturated", 32'd4, n);
      near_saturation <= 1'b0;
      wr(pfpc_pkg::IDX_PERSIST, 8'h10);
      start(1'b0);
      wr(pfpc_pkg::IDX_PERSIST, 8'h20);
      send(1'b0, 1'b0, 0, ev);
      send(1'b0, 1'b1, 1, ev);
      check("late code", 32'h1, ev);
      wr(pfpc_pkg::IDX_INT_CTRL, 8'h01);
      repeat (3) @(posedge pclk);
      check("light flag", 32'h1, light_int_flag);
      check("int pin", 32'h1, int_pin);
      check("prox flag", 32'h1, prox_int_flag);
      wr(pfpc_pkg::IDX_INT_STATUS, 8'h01);
      repeat (3) @(posedge pclk);
      check("light flag", 32'h0, light_int_flag);
      check("int pin", 32'h0, int_pin);
      check("prox flag kept", 32'h1, prox_int_flag);
      finish_test();
   end
endmodule
